// >>> core/l2se_pkg.sv
package l2se_pkg;
   // ==========================================================
   // Sizes
   localparam int NPORT = 13;
   localparam int PORT_W = 4;
   localparam int MAC_W = 48;
   localparam int KEY_W = 10;
   localparam int IDX_W = 11;
   localparam int TBL_N = 2048;
   localparam int FCB_W = 10;
   localparam int CNT_W = 8;
   localparam int NFT = 3;
   localparam int NPEND = 5;
   localparam int TBU_W = 20;
   localparam int HDR_BYTES = 64;
   localparam logic [PORT_W-1:0] CPU_PORT = 4'hF;
   // ==========================================================
   // Timing
   localparam int CLK_NS = 40;
   localparam int TB_UNIT_NS = 100000;
   localparam int TB_UNIT_CYC = (TB_UNIT_NS + CLK_NS - 1) / CLK_NS;
   // ==========================================================
   // Header byte offsets
   localparam logic [5:0] HDR_LAST = 6'(HDR_BYTES - 1);
   localparam logic [5:0] OFS_DA = 6'h00;
   localparam logic [5:0] OFS_SA = 6'h06;
   localparam logic [5:0] OFS_PROTO = 6'h17;
   localparam logic [5:0] OFS_SIP = 6'h1A;
   localparam logic [23:0] IGMP_DA_OUI = 24'h01005E;
   localparam logic [7:0] IGMP_PROTO = 8'h02;
   localparam logic [23:0] IGMP_SIP_NET = 24'hE00000;
   // ==========================================================
   // Encodings
   localparam logic [1:0] SW_LEARNING = 2'h2;
   localparam logic [1:0] SW_FORWARDING = 2'h3;
   localparam logic [1:0] RES_FWD = 2'h0;
   localparam logic [1:0] RES_FLOOD = 2'h1;
   localparam logic [1:0] RES_RELEASE = 2'h2;
   localparam int FT_UC_FLOOD = 0;
   localparam int FT_UC_CPU = 1;
   localparam int FT_MC_CPU = 2;
   localparam int MSG_LEARNED = 0;
   localparam int MSG_LEARN_REQ = 1;
   localparam int MSG_VLAN_VIOL = 2;
   localparam int MSG_IGMP = 3;
   localparam int MSG_MREQ_DONE = 4;
   localparam logic [2:0] MSG_AGED = 3'h5;
   // ==========================================================
   // Types
   typedef enum logic [1:0] {S_IDLE, S_HDR, S_SRCH, S_MSG} l2se_fsm_t;
   typedef struct packed {
      logic valid;
      logic stat;
      logic age;
      logic dfilt;
      logic sfilt;
      logic [PORT_W-1:0] port;
      logic [MAC_W-1:0] mac;
   } l2se_ent_t;
   typedef struct packed {
      l2se_fsm_t state;
      logic [5:0] bcnt;
      logic [MAC_W-1:0] da;
      logic [MAC_W-1:0] sa;
      logic [7:0] proto;
      logic [23:0] sip;
      logic [PORT_W-1:0] sport;
      logic [FCB_W-1:0] fcb;
      logic [NPORT-1:0] vports;
      l2se_ent_t [TBL_N-1:0] tbl;
      logic [IDX_W-1:0] age_ptr;
      logic [IDX_W-1:0] age_idx;
      logic age_pend;
      logic [NPEND-1:0] pend;
      logic [MAC_W-1:0] pm_mac;
      logic [PORT_W-1:0] pm_port;
      logic [IDX_W-1:0] pm_idx;
      logic [TBU_W-1:0] tb_unit;
      logic [6:0] tb_units;
      logic hdr_ready;
      logic res_valid;
      logic [1:0] res_code;
      logic [PORT_W-1:0] res_port;
      logic [FCB_W-1:0] res_fcb;
      logic mreq_ack;
      logic msg_wr;
      logic [2:0] msg_code;
      logic [MAC_W-1:0] msg_mac;
      logic [PORT_W-1:0] msg_port;
      logic [IDX_W-1:0] msg_idx;
   } l2se_st_t;
endpackage

// >>> core/l2se_flood_if.sv
`timescale 1ns/1ns
`default_nettype none
interface l2se_flood_if;
   import l2se_pkg::*;
   logic [NFT-1:0] inc;
   logic clr;
   logic [NFT-1:0][CNT_W-1:0] lim;
   logic [NFT-1:0] over;
   modport eng (output inc, output clr, output lim, input over);
   modport ctr (input inc, input clr, input lim, output over);
endinterface
`default_nettype wire

// >>> core/l2se_flood_ctr.sv
`timescale 1ns/1ns
`default_nettype none
module l2se_flood_ctr
   import l2se_pkg::*;
#(
   parameter int NT = NFT
)(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Engine side
   l2se_flood_if.ctr fl
);
   typedef struct packed {
      logic [NT-1:0][CNT_W-1:0] cnt;
   } l2se_fc_t;
   l2se_fc_t st_ff;
   l2se_fc_t nxt;

   // ==========================================================
   // Counters
   always_comb
   begin
      nxt = st_ff;
      for (int t = 0; t < NT; t++)
      begin
         if (fl.clr)
            nxt.cnt[t] = '0;
         else if (fl.inc[t] && st_ff.cnt[t] != {CNT_W{1'b1}})
            nxt.cnt[t] = st_ff.cnt[t] + 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         st_ff <= '0;
      else
         st_ff <= nxt;
   end

   // Limit already reached: this packet is the one that exceeds it
   for (genvar t = 0; t < NT; t++)
   begin : g_over
      assign fl.over[t] = st_ff.cnt[t] >= fl.lim[t];
   end

   // ==========================================================
   // Checks
   property p_clr_wins;
      @(posedge i_clk) disable iff (!i_rst_n)
      (fl.clr && (|fl.inc)) |=> (st_ff.cnt == '0);
   endproperty
   a_clr_wins: assert property (p_clr_wins) else $error("clear lost to increment");

   property p_count;
      @(posedge i_clk) disable iff (!i_rst_n)
      (fl.inc[0] && !fl.clr && st_ff.cnt[0] != {CNT_W{1'b1}})
         |=> (st_ff.cnt[0] == $past(st_ff.cnt[0]) + 1'b1);
   endproperty
   a_count: assert property (p_count) else $error("flood count not advanced");

   property p_hold_over;
      @(posedge i_clk) disable iff (!i_rst_n)
      (fl.over[1] && !fl.clr && $stable(fl.lim)) |=> fl.over[1];
   endproperty
   a_hold_over: assert property (p_hold_over) else $error("over dropped in period");
endmodule // l2se_flood_ctr
`default_nettype wire

// >>> core/l2se_top.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Search starts on 64 parsed header bytes
// - Table holds 2k MAC control entries
// - Four selectable hashes, 8/9/10 bit keys
// - Search only in forwarding or learning
// - Both addresses looked up; VLAN optional
// - Unaware: filter check, source miss learns
// - Aware: source hit checks source membership, destination membership only on a destination hit
// - Violation: forward/drop by config, notify processor
// - Global learn disable gates source-miss learning, not processor requests
// - Source miss creates entry, reports learned
// - Queue 3/4 full: processor learns instead
// - Processor requests learn or port change
// - Unknown destination floods to all ports
// - Flood time base 100us to 12.8ms
// - Three flood counters per port, limits
// - Over limit: drop type until period end
// - Period end clears all flood counters
// - Destination filter flag releases frame buffer
// - Source filter flag releases frame buffer
// - Aging scans one entry per clock
// - Source hit sets age; static never ages
// - Messages to processor through FIFO, event
module l2se_top
   import l2se_pkg::*;
#(
   parameter int TB_UNIT_CYC_P = TB_UNIT_CYC
)(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Configuration
   input wire logic i_global_learn_disable,
   input wire logic i_vlan_en,
   input wire logic i_viol_fwd,
   input wire logic [1:0] i_hash_sel,
   input wire logic [1:0] i_sw_state,
   input wire logic i_age_en,
   input wire logic [6:0] i_flood_tbase,
   input wire logic [CNT_W-1:0] i_lim_uc_flood,
   input wire logic [CNT_W-1:0] i_lim_uc_cpu,
   input wire logic [CNT_W-1:0] i_lim_mc_cpu,
   // Header from frame engine
   input wire logic i_hdr_valid,
   input wire logic [7:0] i_hdr_byte,
   input wire logic [PORT_W-1:0] i_hdr_port,
   input wire logic [FCB_W-1:0] i_hdr_fcb,
   input wire logic [NPORT-1:0] i_hdr_vlan_ports,
   input wire logic i_req_q_34full,
   output logic o_hdr_ready,
   // Result to frame engine
   output logic o_res_valid,
   output logic [1:0] o_res_code,
   output logic [PORT_W-1:0] o_res_port,
   output logic [FCB_W-1:0] o_res_fcb,
   // Requests from management processor
   input wire logic i_mreq_valid,
   input wire logic i_mreq_del,
   input wire logic i_mreq_static,
   input wire logic [MAC_W-1:0] i_mreq_mac,
   input wire logic [PORT_W-1:0] i_mreq_port,
   output logic o_mreq_ack,
   // Message FIFO to management processor
   input wire logic i_msg_full,
   output logic o_msg_wr,
   output logic [2:0] o_msg_code,
   output logic [MAC_W-1:0] o_msg_mac,
   output logic [PORT_W-1:0] o_msg_port,
   output logic [IDX_W-1:0] o_msg_idx
);
   l2se_st_t st_ff;
   l2se_st_t nxt;

   // ==========================================================
   // Hash and lookup
   // Changing the hash selection strands existing entries; flush first
   function automatic logic [KEY_W-1:0] hkey(logic [1:0] s, logic [MAC_W-1:0] m);
      unique case (s)
         2'h0: hkey = m[9:0];
         2'h1: hkey = m[47:38];
         2'h2: hkey = {1'b0, m[8:0] ^ m[32:24]};
         2'h3: hkey = {2'b0, m[7:0] ^ m[15:8] ^ m[23:16]};
      endcase
   endfunction

   // Two ways per bucket; returns {hit, index}
   function automatic logic [IDX_W:0] find(l2se_st_t s, logic [KEY_W-1:0] k,
                                           logic [MAC_W-1:0] m, logic want_free);
      l2se_ent_t e0;
      l2se_ent_t e1;
      e0 = s.tbl[{k, 1'b0}];
      e1 = s.tbl[{k, 1'b1}];
      if (want_free)
         find = !e0.valid ? {1'b1, k, 1'b0} : (!e1.valid ? {1'b1, k, 1'b1} : '0);
      else if (e0.valid && e0.mac == m)
         find = {1'b1, k, 1'b0};
      else if (e1.valid && e1.mac == m)
         find = {1'b1, k, 1'b1};
      else
         find = '0;
   endfunction

   function automatic logic member(logic [NPORT-1:0] v, logic [PORT_W-1:0] p);
      member = (p >= PORT_W'(NPORT)) ? 1'b1 : v[p];
   endfunction

   logic [KEY_W-1:0] dkey;
   logic [KEY_W-1:0] skey;
   logic [KEY_W-1:0] mkey;
   logic [IDX_W:0] dfind;
   logic [IDX_W:0] sfind;
   logic [IDX_W:0] sfree;
   logic [IDX_W:0] mfind;
   logic [IDX_W:0] mfree;
   l2se_ent_t dent;
   l2se_ent_t sent;
   logic dhit;
   logic shit;
   logic search_ok;
   logic mc;
   logic igmp;
   logic viol;
   logic learn_want;
   logic [NFT-1:0] ft;
   logic [NFT-1:0] fl_over;
   logic [NFT-1:0] fl_inc;
   logic drop_fl;
   logic take;
   logic [5:0] bidx;
   logic unit_wrap;
   logic period_end;

   assign dkey = hkey(i_hash_sel, st_ff.da);
   assign skey = hkey(i_hash_sel, st_ff.sa);
   assign mkey = hkey(i_hash_sel, i_mreq_mac);
   assign dfind = find(st_ff, dkey, st_ff.da, 1'b0);
   assign sfind = find(st_ff, skey, st_ff.sa, 1'b0);
   assign sfree = find(st_ff, skey, st_ff.sa, 1'b1);
   assign mfind = find(st_ff, mkey, i_mreq_mac, 1'b0);
   assign mfree = find(st_ff, mkey, i_mreq_mac, 1'b1);
   assign dhit = dfind[IDX_W];
   assign shit = sfind[IDX_W];
   assign dent = st_ff.tbl[dfind[IDX_W-1:0]];
   assign sent = st_ff.tbl[sfind[IDX_W-1:0]];
   assign search_ok = (i_sw_state == SW_LEARNING) || (i_sw_state == SW_FORWARDING);
   assign mc = st_ff.da[40];
   assign igmp = (st_ff.da[47:24] == IGMP_DA_OUI) && (st_ff.proto == IGMP_PROTO)
                 && (st_ff.sip == IGMP_SIP_NET);
   // Membership is only checked once the source entry is known
   assign viol = i_vlan_en && shit && (!member(st_ff.vports, st_ff.sport)
                 || (dhit && !member(st_ff.vports, dent.port)));
   assign learn_want = !shit && !i_global_learn_disable;
   assign take = i_hdr_valid && st_ff.hdr_ready;
   assign bidx = (st_ff.state == S_IDLE) ? OFS_DA : st_ff.bcnt;

   // ==========================================================
   // Flood control
   assign ft[FT_UC_FLOOD] = !mc && !dhit;
   assign ft[FT_UC_CPU] = !mc && dhit && (dent.port == CPU_PORT);
   assign ft[FT_MC_CPU] = igmp;
   assign unit_wrap = st_ff.tb_unit == TBU_W'(TB_UNIT_CYC_P - 1);
   assign period_end = unit_wrap && (st_ff.tb_units == i_flood_tbase);

   logic [NPORT-1:0][NFT-1:0] over_all;
   l2se_flood_if fif [NPORT] ();
   for (genvar g = 0; g < NPORT; g++)
   begin : g_fl
      assign fif[g].inc = (st_ff.sport == PORT_W'(g)) ? fl_inc : '0;
      assign fif[g].clr = period_end;
      assign fif[g].lim = {i_lim_mc_cpu, i_lim_uc_cpu, i_lim_uc_flood};
      assign over_all[g] = fif[g].over;
      l2se_flood_ctr #(.NT(NFT)) u_ctr (.i_clk(i_clk), .i_rst_n(i_rst_n), .fl(fif[g].ctr));
   end
   assign fl_over = (st_ff.sport < PORT_W'(NPORT)) ? over_all[st_ff.sport] : '0;
   assign drop_fl = |(ft & fl_over);

   // ==========================================================
   // Next state
   always_comb
   begin
      nxt = st_ff;
      fl_inc = '0;
      nxt.res_valid = 1'b0;
      nxt.mreq_ack = 1'b0;
      nxt.msg_wr = 1'b0;
      if (unit_wrap)
      begin
         nxt.tb_unit = '0;
         nxt.tb_units = period_end ? '0 : st_ff.tb_units + 1'b1;
      end
      else
         nxt.tb_unit = st_ff.tb_unit + 1'b1;
      // Scan stalls while an aged entry waits for the FIFO
      if (i_age_en && !st_ff.age_pend)
      begin
         nxt.age_ptr = st_ff.age_ptr + 1'b1;
         if (st_ff.tbl[st_ff.age_ptr].valid && !st_ff.tbl[st_ff.age_ptr].stat)
         begin
            if (st_ff.tbl[st_ff.age_ptr].age)
               nxt.tbl[st_ff.age_ptr].age = 1'b0;
            else
            begin
               nxt.age_pend = 1'b1;
               nxt.age_idx = st_ff.age_ptr;
            end
         end
      end
      if (st_ff.age_pend && !i_msg_full && st_ff.state != S_MSG)
      begin
         nxt.age_pend = 1'b0;
         nxt.msg_wr = 1'b1;
         nxt.msg_code = MSG_AGED;
         nxt.msg_mac = st_ff.tbl[st_ff.age_idx].mac;
         nxt.msg_port = st_ff.tbl[st_ff.age_idx].port;
         nxt.msg_idx = st_ff.age_idx;
      end
      unique case (st_ff.state)
         S_IDLE, S_HDR:
         begin
            if (take)
            begin
               if (st_ff.state == S_IDLE)
               begin
                  nxt.sport = i_hdr_port;
                  nxt.fcb = i_hdr_fcb;
                  nxt.vports = i_hdr_vlan_ports;
               end
               if (bidx < OFS_SA)
                  nxt.da = {st_ff.da[39:0], i_hdr_byte};
               else if (bidx < OFS_SA + 6'h06)
                  nxt.sa = {st_ff.sa[39:0], i_hdr_byte};
               if (bidx == OFS_PROTO)
                  nxt.proto = i_hdr_byte;
               if (bidx >= OFS_SIP && bidx < OFS_SIP + 6'h03)
                  nxt.sip = {st_ff.sip[15:0], i_hdr_byte};
               nxt.bcnt = bidx + 1'b1;
               nxt.state = (bidx == HDR_LAST) ? S_SRCH : S_HDR;
            end
            else if (st_ff.state == S_IDLE && i_mreq_valid)
            begin
               nxt.mreq_ack = 1'b1;
               nxt.pend[MSG_MREQ_DONE] = 1'b1;
               nxt.pm_mac = i_mreq_mac;
               nxt.pm_port = i_mreq_port;
               nxt.pm_idx = mfind[IDX_W] ? mfind[IDX_W-1:0] : mfree[IDX_W-1:0];
               nxt.state = S_MSG;
               if (mfind[IDX_W] && i_mreq_del)
                  nxt.tbl[mfind[IDX_W-1:0]].valid = 1'b0;
               else if (mfind[IDX_W])
               begin
                  nxt.tbl[mfind[IDX_W-1:0]].port = i_mreq_port;
                  nxt.tbl[mfind[IDX_W-1:0]].stat = i_mreq_static;
                  nxt.tbl[mfind[IDX_W-1:0]].age = 1'b1;
               end
               else if (mfree[IDX_W] && !i_mreq_del)
                  nxt.tbl[mfree[IDX_W-1:0]] = '{1'b1, i_mreq_static, 1'b1, 1'b0, 1'b0,
                                                 i_mreq_port, i_mreq_mac};
            end
         end
         S_SRCH:
         begin
            nxt.res_valid = 1'b1;
            nxt.res_fcb = st_ff.fcb;
            nxt.res_port = dent.port;
            nxt.pm_mac = st_ff.sa;
            nxt.pm_port = st_ff.sport;
            nxt.pm_idx = shit ? sfind[IDX_W-1:0] : sfree[IDX_W-1:0];
            nxt.state = S_MSG;
            if (!search_ok)
               nxt.res_code = RES_RELEASE;
            else
            begin
               fl_inc = ft;
               if (shit)
                  nxt.tbl[sfind[IDX_W-1:0]].age = 1'b1;
               else if (learn_want && !i_req_q_34full && sfree[IDX_W])
               begin
                  nxt.tbl[sfree[IDX_W-1:0]] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0,
                                                 st_ff.sport, st_ff.sa};
                  nxt.pend[MSG_LEARNED] = 1'b1;
               end
               else if (learn_want && !i_msg_full)
                  nxt.pend[MSG_LEARN_REQ] = 1'b1;
               nxt.pend[MSG_VLAN_VIOL] = viol;
               nxt.pend[MSG_IGMP] = igmp;
               if ((dhit && dent.dfilt) || (shit && sent.sfilt) || drop_fl
                   || (viol && !i_viol_fwd) || i_sw_state == SW_LEARNING)
                  nxt.res_code = RES_RELEASE;
               else if (dhit)
                  nxt.res_code = RES_FWD;
               else
                  nxt.res_code = RES_FLOOD;
            end
         end
         S_MSG:
         begin
            if (st_ff.pend == '0)
               nxt.state = S_IDLE;
            else if (!i_msg_full)
            begin
               for (int i = NPEND - 1; i >= 0; i--)
               begin
                  if (st_ff.pend[i])
                     nxt.msg_code = 3'(i);
               end
               nxt.pend = st_ff.pend & (st_ff.pend - 1'b1);
               nxt.msg_wr = 1'b1;
               nxt.msg_mac = st_ff.pm_mac;
               nxt.msg_port = st_ff.pm_port;
               nxt.msg_idx = st_ff.pm_idx;
            end
         end
      endcase
      nxt.hdr_ready = (nxt.state == S_IDLE) || (nxt.state == S_HDR);
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         st_ff <= '0;
      else
         st_ff <= nxt;
   end

   assign o_hdr_ready = st_ff.hdr_ready;
   assign o_res_valid = st_ff.res_valid;
   assign o_res_code = st_ff.res_code;
   assign o_res_port = st_ff.res_port;
   assign o_res_fcb = st_ff.res_fcb;
   assign o_mreq_ack = st_ff.mreq_ack;
   assign o_msg_wr = st_ff.msg_wr;
   assign o_msg_code = st_ff.msg_code;
   assign o_msg_mac = st_ff.msg_mac;
   assign o_msg_port = st_ff.msg_port;
   assign o_msg_idx = st_ff.msg_idx;

   // ==========================================================
   // Checks
   sequence s_last_byte;
      take && st_ff.state == S_HDR && st_ff.bcnt == HDR_LAST;
   endsequence
   property p_result;
      @(posedge i_clk) disable iff (!i_rst_n)
      s_last_byte |=> (st_ff.state == S_SRCH && !o_hdr_ready) ##1 o_res_valid;
   endproperty
   a_result: assert property (p_result) else $error("no result after header");

   property p_no_search;
      @(posedge i_clk) disable iff (!i_rst_n)
      (st_ff.state == S_SRCH && !search_ok) |=> (o_res_code == RES_RELEASE && st_ff.pend == '0);
   endproperty
   a_no_search: assert property (p_no_search) else $error("search outside allowed state");

   property p_dfilt;
      @(posedge i_clk) disable iff (!i_rst_n)
      (st_ff.state == S_SRCH && search_ok && dhit && dent.dfilt)
         |=> (o_res_valid && o_res_code == RES_RELEASE);
   endproperty
   a_dfilt: assert property (p_dfilt) else $error("filtered destination not released");

   property p_learn;
      @(posedge i_clk) disable iff (!i_rst_n)
      (st_ff.state == S_SRCH && search_ok && learn_want && !i_req_q_34full && sfree[IDX_W])
         |=> (st_ff.tbl[$past(sfree[IDX_W-1:0])].valid
              && st_ff.tbl[$past(sfree[IDX_W-1:0])].mac == $past(st_ff.sa)
              && st_ff.pend[MSG_LEARNED]);
   endproperty
   a_learn: assert property (p_learn) else $error("source miss not learned");

   property p_gld;
      @(posedge i_clk) disable iff (!i_rst_n)
      (st_ff.state == S_SRCH && i_global_learn_disable)
         |=> (!st_ff.pend[MSG_LEARNED] && !st_ff.pend[MSG_LEARN_REQ]);
   endproperty
   a_gld: assert property (p_gld) else $error("learning while disabled");

   property p_age;
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_age_en && !st_ff.age_pend && st_ff.tbl[st_ff.age_ptr].valid
       && !st_ff.tbl[st_ff.age_ptr].stat && !st_ff.tbl[st_ff.age_ptr].age)
         |=> (st_ff.age_pend && st_ff.age_idx == $past(st_ff.age_ptr));
   endproperty
   a_age: assert property (p_age) else $error("aged entry not reported");

   property p_msg_room;
      @(posedge i_clk) disable iff (!i_rst_n)
      o_msg_wr |-> $past(!i_msg_full);
   endproperty
   a_msg_room: assert property (p_msg_room) else $error("message written into full FIFO");
endmodule // l2se_top
`default_nettype wire

// >>> tb/l2se_fe_model.sv
`timescale 1ns/1ns
`default_nettype none
module l2se_fe_model
   import l2se_pkg::*;
(
   // Clock and handshake
   input wire logic i_clk,
   input wire logic i_ready,
   // Header bytes
   output logic o_valid,
   output logic [7:0] o_byte,
   output logic [PORT_W-1:0] o_port
);
   initial
   begin
      o_valid = 1'b0;
      o_byte = 8'h00;
      o_port = '0;
   end
   // ==========================================================
   // One header: each byte is held until ready is seen at an edge
   task automatic send(input logic [MAC_W-1:0] da, input logic [MAC_W-1:0] sa,
      input logic [PORT_W-1:0] p);
      logic [8*HDR_BYTES-1:0] h;
      h = '0;
      h[8*HDR_BYTES-1 -: 96] = {da, sa};
      for (int i = 0; i < HDR_BYTES; i++)
      begin
         @(negedge i_clk);
         o_valid = 1'b1;
         o_byte = h[8*(HDR_BYTES-i)-1 -: 8];
         o_port = p;
         while (!i_ready) @(negedge i_clk);
         @(posedge i_clk);
      end
      @(negedge i_clk);
      o_valid = 1'b0;
      // Released lines must not look like a held byte
      o_byte = ~o_byte;
   endtask
endmodule // l2se_fe_model
`default_nettype wire

// >>> tb/l2se_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module l2se_top_tb;
   import l2se_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, gld = 1'b0, ven = 1'b0, q34 = 1'b0, mv = 1'b0;
   logic [1:0] sws = 2'h3;
   logic [7:0] lim = 8'hFF;
   logic [MAC_W-1:0] mmac = '0;
   logic hv, rv, ack, mw;
   logic [7:0] hb;
   logic [3:0] hp, rp;
   logic [1:0] rc;
   logic [2:0] mc;
   logic dut_rdy, vf = 1'b0, aen = 1'b0, mf = 1'b0, mdel = 1'b0;
   logic [1:0] hs = 2'h0;
   logic [3:0] mport = 4'h5, op;
   logic [9:0] fcb = 10'h2A5, rf;
   logic [12:0] vp = 13'h0000;
   logic [47:0] om;
   logic [10:0] oi;
   int fail_count = 0, samples_checked = 0, cyc = 0;
   always #20 clk = ~clk;
   l2se_fe_model fe (.i_clk(clk), .i_ready(dut_rdy), .o_valid(hv), .o_byte(hb), .o_port(hp));
   // Long period keeps every scenario inside one flood window
   l2se_top #(.TB_UNIT_CYC_P(2500)) dut (.i_clk(clk), .i_rst_n(rst_n),
      .i_global_learn_disable(gld), .i_vlan_en(ven), .i_viol_fwd(vf), .i_hash_sel(hs),
      .i_sw_state(sws), .i_age_en(aen), .i_flood_tbase(7'h03), .i_lim_uc_flood(lim),
      .i_lim_uc_cpu(8'hFF), .i_lim_mc_cpu(8'hFF), .i_hdr_valid(hv), .i_hdr_byte(hb),
      .i_hdr_port(hp), .i_hdr_fcb(fcb), .i_hdr_vlan_ports(vp),
      .i_req_q_34full(q34), .o_hdr_ready(dut_rdy), .o_res_valid(rv), .o_res_code(rc),
      .o_res_port(rp), .o_res_fcb(rf), .i_mreq_valid(mv), .i_mreq_del(mdel),
      .i_mreq_static(1'b0), .i_mreq_mac(mmac), .i_mreq_port(mport), .o_mreq_ack(ack),
      .i_msg_full(mf), .o_msg_wr(mw), .o_msg_code(mc), .o_msg_mac(om), .o_msg_port(op),
      .o_msg_idx(oi));
   // ==========================================================
   // Checking helpers
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic pkt(input logic [47:0] da, sa, input logic [3:0] p, input logic [1:0] ec,
      input logic [3:0] ep);
      // No captured result leaves an impossible code
      logic [7:0] g = 8'hFF;
      fe.send(da, sa, p);
      for (int i = 0; i < 8 && g == 8'hFF; i++)
      begin
         if (rv === 1'b1) g = {2'h0, rc, rp};
         else @(negedge clk);
      end
      chk({6'h0, g[5:4]}, {6'h0, ec});
      chk(rf[7:0], fcb[7:0]);
      if (ec == RES_FWD) chk({4'h0, g[3:0]}, {4'h0, ep});
   endtask
   task automatic msg(input logic [2:0] ec);
      logic [2:0] g = 3'h7;
      for (int i = 0; i < 20 && g == 3'h7; i++)
      begin
         @(negedge clk);
         if (mw === 1'b1) g = mc;
      end
      chk({5'h0, g}, {5'h0, ec});
   endtask
   task automatic nomsg();
      logic s = 1'b0;
      repeat (12) @(negedge clk) s |= (mw !== 1'b0);
      chk({7'h0, s}, 8'h00);
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_learn_fwd();
      pkt(48'hA, 48'hB, 4'h1, RES_FLOOD, 4'h0);
      msg(3'(MSG_LEARNED));
      pkt(48'hB, 48'hA, 4'h2, RES_FWD, 4'h1);
      msg(3'(MSG_LEARNED));
      $display("test learn_fwd done");
   endtask
   task automatic t_state_gln_q34();
      sws = 2'h0;
      pkt(48'hB, 48'hA, 4'h2, RES_RELEASE, 4'h0);
      sws = 2'h3;
      gld = 1'b1;
      pkt(48'hB, 48'hC, 4'h3, RES_FWD, 4'h1);
      nomsg();
      gld = 1'b0;
      q34 = 1'b1;
      pkt(48'hB, 48'hD, 4'h2, RES_FWD, 4'h1);
      msg(3'(MSG_LEARN_REQ));
      q34 = 1'b0;
      $display("test state_gln_q34 done");
   endtask
   task automatic t_mreq();
      int n = 0;
      @(negedge clk);
      // Learning is off while the processor edits entries
      gld = 1'b1;
      mf = 1'b1;
      mmac = 48'hE;
      mv = 1'b1;
      while (ack !== 1'b1 && n < 20)
      begin
         @(negedge clk);
         n++;
      end
      mv = 1'b0;
      chk({7'h0, ack}, 8'h01);
      nomsg();
      mf = 1'b0;
      msg(3'(MSG_MREQ_DONE));
      pkt(48'hE, 48'hB, 4'h1, RES_FWD, 4'h5);
      gld = 1'b0;
      $display("test mreq done");
   endtask
   task automatic t_vlan_flood();
      ven = 1'b1;
      pkt(48'hA, 48'hB, 4'h1, RES_RELEASE, 4'h0);
      msg(3'(MSG_VLAN_VIOL));
      vf = 1'b1;
      pkt(48'hA, 48'hB, 4'h1, RES_FWD, 4'h2);
      msg(3'(MSG_VLAN_VIOL));
      vf = 1'b0;
      vp = 13'h0006;
      pkt(48'hA, 48'hB, 4'h1, RES_FWD, 4'h2);
      nomsg();
      vp = 13'h0000;
      ven = 1'b0;
      lim = 8'h01;
      pkt(48'hF, 48'hA, 4'h7, RES_FLOOD, 4'h0);
      pkt(48'hF, 48'hA, 4'h7, RES_RELEASE, 4'h0);
      $display("test vlan_flood done");
   endtask
   task automatic t_age();
      int n = 0;
      // First sweep clears the flags, the second reports the lowest entry
      aen = 1'b1;
      while (mw !== 1'b1 && n < 2200)
      begin
         @(negedge clk);
         n++;
      end
      chk({5'h0, mc}, {5'h0, MSG_AGED});
      chk(om[7:0], 8'h0A);
      chk({4'h0, op}, 8'h02);
      chk(oi[7:0], 8'h14);
      aen = 1'b0;
      $display("test age done");
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         finish_test();
      end
   end
   initial
   begin
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      t_learn_fwd();
      t_state_gln_q34();
      t_mreq();
      t_vlan_flood();
      t_age();
      finish_test();
   end
endmodule // l2se_top_tb
`default_nettype wire
